// [pssp_sram_dev.sv]
// device end: 256k x 18 pipelined synchronous sram with burst counter
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - all synchronous inputs captured on rising edge
// - read data launched from output register
// - clock gate high freezes all internal state
// - reads and writes back to back, no idles
// - byte lane writes only with write request
// - controller starts write with write request low
// - writes self-timed from the clock
// - three chip selects sampled on rising edge
// - drivers off during write data phase
// - output enable gates drivers asynchronously
// - address selects one of 256k 18-bit words
// - low two address bits load burst counter
// - step high and gate low advance counter
// - step low loads a fresh address
// - controller loads new address after deselect
// - selected only with all three selects active
// - outputs off while deselected and right after
// - strap low linear, high interleaved burst order
// - parity lanes follow their byte lane writes
module pssp_sram_dev #(
  parameter int ADDR_W = pssp_pkg::ADDR_W
) (
  // pins shared with the controller
  pssp_if.dev link,
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // burst order strap
  input wire logic i_burst_order
);
  import pssp_pkg::*;

  // beat timing, counted in enabled edges only (gated edges do not count):
  //   e0  pins land in stage 1; a load takes address, type and selects,
  //       a step takes the next word of the running group
  //   e1  stage 2; the word is looked up for a read
  //   e2  stage 3; read data and drive flop are loaded, or for a write the
  //       data phase opens and the controller owns the bus
  //   e3  a write commits the enabled lanes of the bus word
  // a read leaves the bus at e3 exactly when a following write takes it,
  // so turnarounds need no idle beat and the two drivers never overlap
  // limitation: a step issued after a deselect beat stays deselected; the
  // controller is expected to load a fresh address instead
  // a smaller ADDR_W only shrinks the array; the pins keep their width

  localparam int DEPTH = 1 << ADDR_W;

  // storage array, one 18-bit word per location
  logic [DATA_W-1:0] mem [0:DEPTH-1];

  // burst state
  logic act_q;
  logic wr_q;
  logic mode_q;
  logic [ADDR_W-1:0] base_q;
  logic [CNT_W-1:0] cnt_q;
  // command pipeline
  logic s1_vld_q;
  logic s1_wr_q;
  logic [ADDR_W-1:0] s1_addr_q;
  logic [LANES-1:0] s1_lanes_q;
  logic s2_vld_q;
  logic s2_wr_q;
  logic [ADDR_W-1:0] s2_addr_q;
  logic [LANES-1:0] s2_lanes_q;
  logic s3_wr_q;
  logic [ADDR_W-1:0] s3_addr_q;
  logic [LANES-1:0] s3_lanes_q;
  // output stage
  logic drive_q;
  logic [DATA_W-1:0] rd_q;

  ////////////////////////////////////////////////////////////////////////////////
  // command decode on the pins
  // a gated edge must not even advance the counter, so every register below checks en
  wire en = ~link.clock_gate_n;
  wire load = ~link.burst_step_or_load;
  wire sel = ~link.select_first_n & link.select_second & ~link.select_third_n;
  wire [CNT_W-1:0] cnt_next = CNT_W'(cnt_q + 2'h1); // wraps inside the group
  wire [CNT_W-1:0] step_low = burst_low(base_q[CNT_W-1:0], cnt_next, mode_q);
  wire [ADDR_W-1:0] step_addr = {base_q[ADDR_W-1:CNT_W], step_low};
  // a step reuses the context of the last load; only lanes and data are fresh
  wire cmd_act = load ? sel : act_q;
  wire cmd_wr = load ? ~link.write_req_n : wr_q;
  wire [ADDR_W-1:0] cmd_addr = load ? link.addr : step_addr;
  // byte lanes count only on a write beat; parity rides inside each lane
  wire [LANES-1:0] cmd_lanes = cmd_wr ? ~link.byte_lane_wr_n : '0;

  ////////////////////////////////////////////////////////////////////////////////
  // burst context, latched on a load beat only; a deselect load clears act_q
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      act_q <= 1'b0;
      wr_q <= 1'b0;
      mode_q <= BURST_INTERLEAVED;
      base_q <= '0;
    end else if (en && load) begin
      act_q <= sel;
      wr_q <= ~link.write_req_n;
      mode_q <= i_burst_order;
      base_q <= link.addr;
    end
  end

  // beat counter; a step after a deselect keeps the device deselected
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      cnt_q <= '0;
    end else if (en) begin
      if (load) begin
        cnt_q <= '0;
      end else begin
        cnt_q <= cnt_next;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // input register; one command enters every enabled edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s1_vld_q <= 1'b0;
      s1_wr_q <= 1'b0;
      s1_addr_q <= '0;
      s1_lanes_q <= '0;
    end else if (en) begin
      s1_vld_q <= cmd_act;
      s1_wr_q <= cmd_wr;
      s1_addr_q <= cmd_addr;
      s1_lanes_q <= cmd_lanes;
    end
  end

  // lookup stage; it never waits, so a beat moves on every enabled edge
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s2_vld_q <= 1'b0;
      s2_wr_q <= 1'b0;
      s2_addr_q <= '0;
      s2_lanes_q <= '0;
    end else if (en) begin
      s2_vld_q <= s1_vld_q;
      s2_wr_q <= s1_wr_q;
      s2_addr_q <= s1_addr_q;
      s2_lanes_q <= s1_lanes_q;
    end
  end

  // data phase stage; only a live write opens it
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      s3_wr_q <= 1'b0;
      s3_addr_q <= '0;
      s3_lanes_q <= '0;
    end else if (en) begin
      s3_wr_q <= s2_vld_q & s2_wr_q; // write data arrives after this edge
      s3_addr_q <= s2_addr_q;
      s3_lanes_q <= s2_lanes_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // self-timed write: the data phase ends on the next enabled edge, no strobe needed;
  // the array has no reset, so its contents are undefined until first written
  always_ff @(posedge i_sys_clk) begin
    if (en && s3_wr_q) begin
      mem[s3_addr_q] <= lane_merge(mem[s3_addr_q], link.dq, s3_lanes_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // read path; a write committing on the same edge is forwarded so a
  // read right behind a write to the same word never returns stale data
  // the bypass costs one lane merge in front of the output register, but it
  // spares the controller any hazard tracking between beats
  wire fwd_hit = s3_wr_q & (s3_addr_q == s2_addr_q);
  wire [DATA_W-1:0] fwd_lanes_word = lane_merge(mem[s2_addr_q], link.dq, s3_lanes_q);
  wire [DATA_W-1:0] rd_next = fwd_hit ? fwd_lanes_word : mem[s2_addr_q];
  wire rd_beat = s2_vld_q & ~s2_wr_q;

  // drive flop; a deselected or write beat never turns drivers on
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      drive_q <= 1'b0;
    end else if (en) begin
      drive_q <= rd_beat;
    end
  end

  // output data register; holds its word across writes and idle beats
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      rd_q <= '0;
    end else if (en && rd_beat) begin
      rd_q <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // output drivers; the enable is combinational on purpose, it must act without the clock
  // a gated edge leaves the drive flop alone, so a stall keeps the bus as it is
  assign link.dev_dq = rd_q;
  assign link.dev_dq_oe = drive_q & ~link.out_en_n;
endmodule

// [pssp_pkg.sv]
// shared constants and helpers for the pipelined synchronous sram port
package pssp_pkg;
  // memory geometry
  localparam int ADDR_W = 18;
  localparam int LANES = 2;
  localparam int LANE_W = 9;
  localparam int DATA_W = LANES * LANE_W;
  localparam int CNT_W = 2;
  // parity bit position inside each lane (top bit of the lane)
  localparam int PARITY_POS = LANE_W - 1;
  // burst order strap levels
  localparam logic BURST_LINEAR = 1'b0;
  localparam logic BURST_INTERLEAVED = 1'b1;
  // pin reset levels of the controller
  localparam logic GATE_N_RST = 1'b1;
  localparam logic [LANES-1:0] LANES_N_RST = 2'h3;

  // low address bits of the current beat inside a four-word group
  function automatic logic [CNT_W-1:0] burst_low(input logic [CNT_W-1:0] start,
                                                  input logic [CNT_W-1:0] cnt,
                                                  input logic mode);
    logic [CNT_W-1:0] res;
    res = (mode == BURST_LINEAR) ? CNT_W'(start + cnt) : (start ^ cnt);
    return res;
  endfunction

  // replace the enabled byte lanes of old_w with new_w
  function automatic logic [DATA_W-1:0] lane_merge(input logic [DATA_W-1:0] old_w,
                                                    input logic [DATA_W-1:0] new_w,
                                                    input logic [LANES-1:0] en);
    logic [DATA_W-1:0] res;
    res = old_w;
    for (int i = 0; i < LANES; i++) begin
      if (en[i]) begin
        res[i*LANE_W +: LANE_W] = new_w[i*LANE_W +: LANE_W];
      end
    end
    return res;
  endfunction
endpackage

// [pssp_if.sv]
// pin bundle between the sram device end and the memory controller end
`timescale 1ns/1ps
interface pssp_if (
  input wire logic i_sys_clk
);
  import pssp_pkg::*;
  logic [ADDR_W-1:0] addr;
  logic write_req_n;
  logic [LANES-1:0] byte_lane_wr_n;
  logic select_first_n;
  logic select_second;
  logic select_third_n;
  logic burst_step_or_load;
  logic clock_gate_n;
  logic out_en_n;
  logic [DATA_W-1:0] ctl_dq;
  logic ctl_dq_oe;
  logic [DATA_W-1:0] dev_dq;
  logic dev_dq_oe;
  logic [DATA_W-1:0] dq;
  logic dq_contention;

  // resolved data bus; an undriven bus reads as zero
  assign dq = dev_dq_oe ? dev_dq : (ctl_dq_oe ? ctl_dq : '0);
  assign dq_contention = dev_dq_oe & ctl_dq_oe;

  modport dev (
    input addr, write_req_n, byte_lane_wr_n, select_first_n, select_second, select_third_n,
    input burst_step_or_load, clock_gate_n, out_en_n, dq,
    output dev_dq, dev_dq_oe
  );
  modport ctl (
    output addr, write_req_n, byte_lane_wr_n, select_first_n, select_second, select_third_n,
    output burst_step_or_load, clock_gate_n, out_en_n, ctl_dq, ctl_dq_oe,
    input dq
  );
endinterface

// [pssp_sram_ctl.sv]
// controller end: drives the sram pins from a simple request port
`timescale 1ns/1ps
module pssp_sram_ctl #(
  parameter int ADDR_W = pssp_pkg::ADDR_W
) (
  // pins shared with the device
  pssp_if.ctl link,
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // request side
  input wire logic i_stall,
  input wire logic i_req_valid,
  input wire logic i_req_write,
  input wire logic i_req_burst,
  input wire logic [ADDR_W-1:0] i_req_addr,
  input wire logic [pssp_pkg::DATA_W-1:0] i_req_wdata,
  input wire logic [pssp_pkg::LANES-1:0] i_req_lanes,
  input wire logic i_out_disable,
  // answer side
  output logic o_req_ready,
  output logic o_rd_valid,
  output logic [pssp_pkg::DATA_W-1:0] o_rd_data
);
  import pssp_pkg::*;

  // pin registers
  logic gate_n_q;
  logic ready_q;
  logic [ADDR_W-1:0] addr_q;
  logic wr_n_q;
  logic [LANES-1:0] lanes_n_q;
  logic sel_q;
  logic step_q;
  logic oe_n_q;
  // command now on the pins, and its context for a following step
  logic cmd_vld_q;
  logic cmd_wr_q;
  logic [DATA_W-1:0] cmd_data_q;
  logic last_act_q;
  logic last_wr_q;
  // data phase tracking, mirrors the device pipeline
  logic [2:0] c_vld_q;
  logic [2:0] c_wr_q;
  logic [DATA_W-1:0] c_data_q [0:1];
  logic [DATA_W-1:0] dq_q;
  logic dq_oe_q;
  logic rd_valid_q;
  logic [DATA_W-1:0] rd_data_q;

  ////////////////////////////////////////////////////////////////////////////////
  // the device consumes the pins on every edge where the gate pin is low
  wire take = ~gate_n_q;
  // a step is only legal behind an active beat, so a deselect is always followed by a load
  wire step_ok = i_req_burst & last_act_q;
  wire new_act = step_ok | i_req_valid;
  wire new_wr = step_ok ? last_wr_q : i_req_write;

  ////////////////////////////////////////////////////////////////////////////////
  // pin drive; pins hold while stalled so a stretched cycle sees a stable command
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      gate_n_q <= GATE_N_RST;
      ready_q <= 1'b0;
      oe_n_q <= 1'b1;
      addr_q <= '0;
      wr_n_q <= 1'b1;
      lanes_n_q <= LANES_N_RST;
      sel_q <= 1'b0;
      step_q <= 1'b0;
      cmd_vld_q <= 1'b0;
      cmd_wr_q <= 1'b0;
      cmd_data_q <= '0;
      last_act_q <= 1'b0;
      last_wr_q <= 1'b0;
    end else begin
      gate_n_q <= i_stall;
      ready_q <= ~i_stall;
      oe_n_q <= i_out_disable;
      if (take) begin
        step_q <= step_ok;
        lanes_n_q <= ~i_req_lanes;
        cmd_vld_q <= new_act;
        cmd_wr_q <= new_act & new_wr;
        cmd_data_q <= i_req_wdata;
        last_act_q <= new_act;
        last_wr_q <= new_wr;
        if (!step_ok) begin
          addr_q <= i_req_addr;
          sel_q <= i_req_valid;
          wr_n_q <= ~(i_req_valid & i_req_write);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // data phase: write data goes out two enabled edges after the command
  always_ff @(posedge i_sys_clk or posedge i_rst) begin
    if (i_rst) begin
      c_vld_q <= '0;
      c_wr_q <= '0;
      c_data_q <= '{default: '0};
      dq_q <= '0;
      dq_oe_q <= 1'b0;
      rd_valid_q <= 1'b0;
      rd_data_q <= '0;
    end else begin
      rd_valid_q <= 1'b0;
      if (take) begin
        c_vld_q <= {c_vld_q[1:0], cmd_vld_q};
        c_wr_q <= {c_wr_q[1:0], cmd_wr_q};
        c_data_q[0] <= cmd_data_q;
        c_data_q[1] <= c_data_q[0];
        dq_q <= c_data_q[1];
        dq_oe_q <= c_vld_q[1] & c_wr_q[1];
        if (c_vld_q[2] && !c_wr_q[2]) begin
          rd_valid_q <= 1'b1;
          rd_data_q <= link.dq;
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // pin and answer outputs
  assign link.clock_gate_n = gate_n_q;
  assign link.addr = addr_q;
  assign link.write_req_n = wr_n_q;
  assign link.byte_lane_wr_n = lanes_n_q;
  assign link.select_first_n = ~sel_q;
  assign link.select_second = sel_q;
  assign link.select_third_n = ~sel_q;
  assign link.burst_step_or_load = step_q;
  assign link.out_en_n = oe_n_q;
  assign link.ctl_dq = dq_q;
  assign link.ctl_dq_oe = dq_oe_q;
  assign o_req_ready = ready_q;
  assign o_rd_valid = rd_valid_q;
  assign o_rd_data = rd_data_q;
endmodule

// [pssp_chk.sv]
// concurrent checks on the pins between the sram device end and the controller end
`timescale 1ns/1ps
module pssp_chk (
  // clock and reset
  input wire logic i_sys_clk,
  input wire logic i_rst,
  // watched pins
  input wire logic write_req_n,
  input wire logic select_first_n,
  input wire logic select_second,
  input wire logic select_third_n,
  input wire logic burst_step_or_load,
  input wire logic clock_gate_n,
  input wire logic out_en_n,
  input wire logic ctl_dq_oe,
  input wire logic [pssp_pkg::DATA_W-1:0] dev_dq,
  input wire logic dev_dq_oe,
  input wire logic dq_contention
);
  import pssp_pkg::*;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_rst);
  ////////////////////////////////////////////////////////////////////////////////
  // beat decode; all three selects must be active
  wire sel = !select_first_n && select_second && !select_third_n;
  wire go = !clock_gate_n;
  sequence s_rd;
    go && sel && !burst_step_or_load && write_req_n;
  endsequence
  sequence s_wr;
    go && sel && !burst_step_or_load && !write_req_n;
  endsequence
  sequence s_idle;
    go && !sel && !burst_step_or_load;
  endsequence
  ////////////////////////////////////////////////////////////////////////////////
  // apart from a_no_contention and a_oe_async, each shows a relation in time between cause and effect on the wire
  a_no_contention: assert property (!dq_contention)
    else $error("both ends drive the data bus");
  a_oe_async: assert property (out_en_n |-> !dev_dq_oe)
    else $error("device drives while output enable is off");
  a_read_pipe: assert property (s_rd ##1 go ##1 (go && !out_en_n) |=> dev_dq_oe || out_en_n)
    else $error("read data not driven after two enabled edges");
  a_write_gap: assert property (s_wr ##1 go ##1 go |=> ctl_dq_oe && !dev_dq_oe)
    else $error("write data phase not owned by controller");
  a_deselect_off: assert property (s_idle ##1 go ##1 go |=> !dev_dq_oe)
    else $error("device drives after a deselect beat");
  a_gate_data: assert property (clock_gate_n |=> $stable(dev_dq))
    else $error("output data moved on a gated edge");
  a_gate_drive: assert property (clock_gate_n ##1 $stable(out_en_n) |-> $stable(dev_dq_oe))
    else $error("drive state moved on a gated edge");
  a_turnaround: assert property (s_wr ##1 s_rd ##1 go |=> (ctl_dq_oe && !dev_dq_oe)
    ##1 (dev_dq_oe || out_en_n || $past(clock_gate_n)))
    else $error("write to read turnaround broken");
endmodule

// [pssp_tb.sv]
// self-checking bench joining the sram device end to the controller end
`timescale 1ns/1ps
module pssp_tb;
  import pssp_pkg::*;
  localparam logic [11:0] HI = 12'h05a3;
  logic i_sys_clk = 0, i_rst = 1, i_stall = 0, i_req_valid = 0, i_req_write = 0, i_req_burst = 0;
  logic i_burst_order = 0, i_out_disable = 0, o_req_ready, o_rd_valid, rdy_exp = 0;
  logic stall_on = 0, prev_act = 0, wr_b = 0, mode_b = 0;
  logic [ADDR_W-1:0] i_req_addr = '0;
  logic [DATA_W-1:0] i_req_wdata = '0, o_rd_data, mem [64], exp_q [$];
  logic [LANES-1:0] i_req_lanes = '0;
  logic [31:0] seed = 32'h0000_0048;
  logic [5:0] base = '0;
  logic [1:0] beat = '0;
  int bad_count = 0, samples_checked = 0, gen = 0, n_pre = 0;
  always #5 i_sys_clk = ~i_sys_clk;
  ////////////////////////////////////////////////////////////////////////////////
  // the two ends face each other across the pin bundle
  pssp_if i_pssp_if (.i_sys_clk(i_sys_clk));
  pssp_sram_dev i_pssp_sram_dev (.link(i_pssp_if.dev), .i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_burst_order(i_burst_order));
  pssp_sram_ctl i_pssp_sram_ctl (.link(i_pssp_if.ctl), .i_sys_clk(i_sys_clk), .i_rst(i_rst),
    .i_stall(i_stall), .i_req_valid(i_req_valid), .i_req_write(i_req_write), .i_req_burst(i_req_burst),
    .i_req_addr(i_req_addr), .i_req_wdata(i_req_wdata), .i_req_lanes(i_req_lanes),
    .i_out_disable(i_out_disable), .o_req_ready(o_req_ready), .o_rd_valid(o_rd_valid), .o_rd_data(o_rd_data));
  pssp_chk i_pssp_chk (.i_sys_clk(i_sys_clk), .i_rst(i_rst), .write_req_n(i_pssp_if.write_req_n),
    .select_first_n(i_pssp_if.select_first_n), .select_second(i_pssp_if.select_second),
    .select_third_n(i_pssp_if.select_third_n), .burst_step_or_load(i_pssp_if.burst_step_or_load),
    .clock_gate_n(i_pssp_if.clock_gate_n), .out_en_n(i_pssp_if.out_en_n), .ctl_dq_oe(i_pssp_if.ctl_dq_oe),
    .dev_dq(i_pssp_if.dev_dq), .dev_dq_oe(i_pssp_if.dev_dq_oe), .dq_contention(i_pssp_if.dq_contention));
  ////////////////////////////////////////////////////////////////////////////////
  // xorshift source, fixed start so runs repeat
  function logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  task check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task conclude();
    $display("comparisons %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // reference model of one taken beat; bursts stay inside their group of four
  task take();
    logic [5:0] a;
    logic [DATA_W-1:0] w;
    if (i_req_burst && prev_act) begin
      beat = beat + 2'h1;
      a = {base[5:2], mode_b ? base[1:0] ^ beat : base[1:0] + beat};
    end else begin
      beat = '0;
      base = i_req_addr[5:0];
      wr_b = i_req_write;
      mode_b = i_burst_order;
      prev_act = i_req_valid;
      a = base;
    end
    w = mem[a];
    if (i_req_lanes[0]) w[8:0] = i_req_wdata[8:0];
    if (i_req_lanes[1]) w[17:9] = i_req_wdata[17:9];
    if (prev_act && wr_b) mem[a] = w;
    if (prev_act && !wr_b) exp_q.push_back(i_out_disable ? '0 : mem[a]);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  // drive the request port and score the answers on every edge
  always @(posedge i_sys_clk) begin
    logic [31:0] r;
    if (!i_rst) begin
      r = rnd();
      check(DATA_W'(o_req_ready), DATA_W'(rdy_exp));
      check(DATA_W'(i_pssp_if.dq_contention), '0);
      rdy_exp <= !i_stall;
      i_stall <= stall_on && r[31:30] == 2'h0;
      if (o_rd_valid && exp_q.size() == 0) check(DATA_W'(1), '0);
      if (o_rd_valid && exp_q.size() != 0) check(o_rd_data, exp_q.pop_front());
      if (o_req_ready) begin
        take();
        i_req_valid <= gen == 2 && r[1:0] != 2'h0;
        i_req_write <= r[2];
        i_req_burst <= r[3];
        i_req_addr <= {HI, r[9:4]};
        i_req_wdata <= r[27:10];
        i_req_lanes <= r[29:28];
        // preload fills every word back to back so no read sees an unwritten word
        if (gen == 1 && n_pre < 64) begin
          i_req_valid <= 1'b1;
          i_req_write <= 1'b1;
          i_req_burst <= 1'b0;
          i_req_addr <= {HI, 6'(n_pre)};
          i_req_lanes <= 2'h3;
          n_pre++;
        end
      end
    end
  end
  // phases: linear and interleaved order, outputs disabled, stalls on and off
  initial begin
    repeat (10) @(posedge i_sys_clk);
    i_rst <= 0;
    gen <= 1;
    wait (n_pre == 64);
    for (int p = 0; p < 4; p++) begin
      @(posedge i_sys_clk);
      gen <= 2;
      i_burst_order <= p[0];
      i_out_disable <= p == 2;
      stall_on <= p != 3;
      repeat (500) @(posedge i_sys_clk);
      gen <= 0;
      stall_on <= 0;
      repeat (30) @(posedge i_sys_clk);
      check(DATA_W'(exp_q.size()), '0);
    end
    conclude();
  end
  // cut a hang short: the phases need under 3000 cycles
  initial begin
    #100_000;
    bad_count++;
    conclude();
  end
endmodule
